// *** common/plsc_consts.svh ***
`ifndef PLSC_CONSTS_SVH
`define PLSC_CONSTS_SVH

// Register-port map
`define PLSC_ADDR_W 4
`define PLSC_OFF_STATUS 4'h0
`define PLSC_OFF_STRAP 4'h1
`define PLSC_OFF_XOVER 4'h2
`define PLSC_OFF_GPO 4'h3

// Crossover override register fields
`define PLSC_XOVER_OVR_BIT 15
`define PLSC_XOVER_VAL_BIT 0

// Strap register fields
`define PLSC_STRAP_ADDR_LSB 0
`define PLSC_STRAP_MODE_LSB 5
`define PLSC_STRAP_REG_BIT 8
`define PLSC_STRAP_XOV_BIT 9
`define PLSC_STRAP_DONE_BIT 10

// Reset values
`define PLSC_XOVER_RST 16'h0000
`define PLSC_GPO_RST 1'h0

// Settle delay between reset release and strap sampling
`define PLSC_SETTLE_NS 80
`define PLSC_CLK_NS 40
`define PLSC_SETTLE_CYC ((`PLSC_SETTLE_NS + `PLSC_CLK_NS - 1) / `PLSC_CLK_NS)

`endif

// *** common/plsc_pkg.sv ***
package plsc_pkg;

	typedef enum logic [1:0] {
		PLSC_IN_RESET,
		PLSC_SETTLE,
		PLSC_RUN
	} plsc_phase_e;

	typedef struct packed {
		logic speed_fast;
		logic link_up;
		logic carrier;
		logic full_duplex;
	} plsc_status_s;

	typedef struct packed {
		logic [4:0] mgmt_addr;
		logic [2:0] mode;
		logic reg_on;
		logic xover;
	} plsc_strap_s;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} plsc_bus_s;

endpackage

// *** hw/plsc_top.sv ***
// Notes on behaviour
// RL1 - Speed indicator active at 100, inactive 10
// RL2 - Link indicator active when link established
// RL3 - Activity indicator follows active-medium carrier sense
// RL4 - Duplex indicator active in full duplex
// RL5 - Five straps form management address bits
// RL6 - Address bits 0-3 share four indicator pins
// RL7 - Address bit 4 shares general output one
// RL8 - Three mode straps form default mode
// RL9 - Regulator strap high enables core regulator
// RL10 - Crossover enabled when strap high or floating
// RL11 - Register bit 15 overrides strapped crossover
// RL12 - Data valid while decoded nibbles presented
// RL13 - Data valid unused in reduced interface mode
// RL14 - Carrier sense output follows detected carrier
// RL15 - Straps latched on reset rising edge; the code samples them on the mclk edge that ends the settle count
// RL16 - Mode bits loaded from straps at release
// RL17 - Shared pins undriven until capture done
`timescale 1ns/1ps
`include "plsc_consts.svh"

module plsc_top import plsc_pkg::*; #(
	parameter int SETTLE_CYC = `PLSC_SETTLE_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic ext_reset_n,
	// Register port
	input wire logic [`PLSC_ADDR_W-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Link status from the transceiver core
	input wire logic core_speed_fast,
	input wire logic core_link_up,
	input wire logic core_carrier,
	input wire logic core_full_duplex,
	input wire logic core_rx_nibble_valid,
	input wire logic rmii_mode,
	// Dedicated straps
	input wire logic [2:0] mode_strap,
	input wire logic reg_en_strap,
	input wire logic auto_crossover_strap,
	// Shared indicator and address pins
	input wire logic indicator_one_in,
	output logic indicator_one_out,
	output logic indicator_one_oe,
	input wire logic indicator_two_in,
	output logic indicator_two_out,
	output logic indicator_two_oe,
	input wire logic indicator_three_in,
	output logic indicator_three_out,
	output logic indicator_three_oe,
	input wire logic indicator_four_in,
	output logic indicator_four_out,
	output logic indicator_four_oe,
	input wire logic general_out_one_in,
	output logic general_out_one_out,
	output logic general_out_one_oe,
	// Media interface status
	output logic carrier_sense,
	output logic rx_data_valid,
	// Captured configuration
	output logic [4:0] strap_mgmt_addr,
	output logic [2:0] default_mode,
	output logic core_regulator_on,
	output logic auto_crossover_en,
	output logic strap_done
);

	plsc_phase_e phase_q;
	logic [7:0] settle_q;
	plsc_strap_s strap_q;
	plsc_status_s stat_q;
	logic [15:0] xover_q;
	logic gpo_q;
	logic crs_q;
	logic rxdv_q;
	logic [15:0] rdata_q;
	logic drive;

	// Reset release: a short settle, then one sampling edge
	always_ff @(posedge mclk or negedge ext_reset_n) begin
		if (!ext_reset_n) begin
			phase_q <= PLSC_IN_RESET;
			settle_q <= 8'h00;
		end else begin
			unique case (phase_q)
				PLSC_IN_RESET: begin
					phase_q <= PLSC_SETTLE;
					settle_q <= 8'h00;
				end
				PLSC_SETTLE: begin
					if (settle_q >= 8'(SETTLE_CYC - 1)) begin
						phase_q <= PLSC_RUN;
					end
					settle_q <= settle_q + 8'h01;
				end
				PLSC_RUN: begin
					phase_q <= PLSC_RUN;
				end
			endcase
		end
	end

	wire sample_now = (phase_q == PLSC_SETTLE) && (settle_q >= 8'(SETTLE_CYC - 1));

	// Strap capture on the way out of reset
	always_ff @(posedge mclk or negedge ext_reset_n) begin
		if (!ext_reset_n) begin
			strap_q <= '0;
		end else if (sample_now) begin
			strap_q.mgmt_addr <= {general_out_one_in, indicator_four_in, indicator_three_in,
				indicator_two_in, indicator_one_in}; // RL5 RL6 RL7 RL15
			strap_q.mode <= mode_strap; // RL8 RL16
			strap_q.reg_on <= reg_en_strap; // RL9
			strap_q.xover <= auto_crossover_strap; // RL10
		end
	end

	// Status registering
	always_ff @(posedge mclk or negedge ext_reset_n) begin
		if (!ext_reset_n) begin
			stat_q <= '0;
			crs_q <= 1'b0;
			rxdv_q <= 1'b0;
		end else begin
			stat_q.speed_fast <= core_speed_fast; // RL1
			stat_q.link_up <= core_link_up; // RL2
			stat_q.carrier <= core_carrier; // RL3
			stat_q.full_duplex <= core_full_duplex; // RL4
			crs_q <= core_carrier; // RL14
			rxdv_q <= core_rx_nibble_valid && !rmii_mode; // RL12 RL13
		end
	end

	// Software registers
	always_ff @(posedge mclk or negedge ext_reset_n) begin
		if (!ext_reset_n) begin
			xover_q <= `PLSC_XOVER_RST;
			gpo_q <= `PLSC_GPO_RST;
		end else if (reg_wr) begin
			if (reg_addr == `PLSC_OFF_XOVER) begin
				xover_q <= reg_wdata;
			end
			if (reg_addr == `PLSC_OFF_GPO) begin
				gpo_q <= reg_wdata[0];
			end
		end
	end

	// Read data, valid the cycle after the strobe
	always_ff @(posedge mclk or negedge ext_reset_n) begin
		if (!ext_reset_n) begin
			rdata_q <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`PLSC_OFF_STATUS: rdata_q <= {12'h000, stat_q};
				`PLSC_OFF_STRAP: rdata_q <= {5'h00, strap_done, auto_crossover_en,
					strap_q.reg_on, strap_q.mode, strap_q.mgmt_addr};
				`PLSC_OFF_XOVER: rdata_q <= xover_q;
				`PLSC_OFF_GPO: rdata_q <= {15'h0000, gpo_q};
				default: rdata_q <= 16'h0000;
			endcase
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	assign drive = (phase_q == PLSC_RUN); // RL17
	assign reg_rdata = rdata_q;
	assign strap_done = drive;
	assign strap_mgmt_addr = strap_q.mgmt_addr;
	assign default_mode = strap_q.mode;
	assign core_regulator_on = strap_q.reg_on;
	assign auto_crossover_en = xover_q[`PLSC_XOVER_OVR_BIT] ?
		xover_q[`PLSC_XOVER_VAL_BIT] : strap_q.xover; // RL11

	assign indicator_one_out = drive & stat_q.speed_fast;
	assign indicator_two_out = drive & stat_q.link_up;
	assign indicator_three_out = drive & stat_q.carrier;
	assign indicator_four_out = drive & stat_q.full_duplex;
	assign general_out_one_out = drive & gpo_q;
	assign indicator_one_oe = drive;
	assign indicator_two_oe = drive;
	assign indicator_three_oe = drive;
	assign indicator_four_oe = drive;
	assign general_out_one_oe = drive;
	assign carrier_sense = crs_q;
	assign rx_data_valid = rxdv_q;

endmodule

// *** tb/plsc_asserts.sv ***
`timescale 1ns/1ps
module plsc_asserts #(parameter int SETTLE_CYC = 2) (
	// Watched ports
	input wire logic mclk, ext_reset_n, core_speed_fast, core_link_up, core_carrier,
	input wire logic core_rx_nibble_valid, rmii_mode, reg_en_strap, strap_done,
	input wire logic core_regulator_on, indicator_one_in, indicator_two_in,
	input wire logic indicator_three_in, indicator_four_in, general_out_one_in,
	input wire logic indicator_one_out, indicator_two_out, indicator_three_out,
	input wire logic indicator_one_oe, general_out_one_oe, carrier_sense, rx_data_valid,
	input wire logic [2:0] mode_strap, default_mode,
	input wire logic [4:0] strap_mgmt_addr
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!ext_reset_n);
	sequence s_run;
		strap_done && $past(strap_done);
	endsequence
	sequence s_up;
		$past(ext_reset_n);
	endsequence
	chk_speed_ind: assert property (s_run |-> indicator_one_out == $past(core_speed_fast))
		else $error("speed led");
	chk_link_ind: assert property (s_run |-> indicator_two_out == $past(core_link_up))
		else $error("link led");
	chk_act_ind: assert property (s_run |-> indicator_three_out == $past(core_carrier))
		else $error("activity led");
	chk_crs_out: assert property (s_up |-> carrier_sense == $past(core_carrier))
		else $error("carrier sense");
	chk_dv_out: assert property (s_up |->
		rx_data_valid == ($past(core_rx_nibble_valid) && !$past(rmii_mode)))
		else $error("data valid");
	chk_pin_gate: assert property (indicator_one_oe == strap_done &&
		general_out_one_oe == strap_done && (strap_done || !indicator_one_out))
		else $error("pin gate");
	chk_addr_cap: assert property ($rose(strap_done) |-> strap_mgmt_addr ==
		$past({general_out_one_in, indicator_four_in, indicator_three_in,
		indicator_two_in, indicator_one_in})) else $error("addr capture");
	chk_mode_cap: assert property ($rose(strap_done) |->
		default_mode == $past(mode_strap) && core_regulator_on == $past(reg_en_strap))
		else $error("mode capture");
endmodule
bind plsc_top plsc_asserts #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.*);

// *** tb/plsc_board.sv ***
`timescale 1ns/1ps
module plsc_board (
	// Resistors and drivers
	input wire logic [4:0] strap,
	input wire logic [4:0] oe,
	input wire logic [4:0] drv,
	// Pin levels
	output logic [4:0] pin
);
	// Undriven pins fall to their resistor
	assign pin = (oe & drv) | (~oe & strap);
endmodule

// *** tb/plsc_tb.sv ***
`timescale 1ns/1ps
module plsc_tb;
	logic mclk = 0, ext_reset_n = 0, reg_wr = 0, reg_rd = 0, rmii_mode = 0, core_rx_nibble_valid = 0;
	logic core_speed_fast = 1, core_link_up = 1, core_carrier = 1, core_full_duplex = 1;
	logic reg_en_strap = 1, auto_crossover_strap = 0;
	logic [2:0] mode_strap = 3'h5, default_mode;
	logic [3:0] reg_addr = 4'h0;
	logic [4:0] strap = 5'h15, pin, strap_mgmt_addr;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic indicator_one_in, indicator_two_in, indicator_three_in, indicator_four_in;
	logic indicator_one_out, indicator_two_out, indicator_three_out, indicator_four_out;
	logic indicator_one_oe, indicator_two_oe, indicator_three_oe, indicator_four_oe;
	logic general_out_one_in, general_out_one_out, general_out_one_oe;
	logic core_regulator_on, auto_crossover_en, strap_done, carrier_sense, rx_data_valid;
	int err_count = 0, n_checks = 0;
	wire logic [4:0] oe = {general_out_one_oe, indicator_four_oe, indicator_three_oe,
		indicator_two_oe, indicator_one_oe};
	wire logic [4:0] drv = {general_out_one_out, indicator_four_out, indicator_three_out,
		indicator_two_out, indicator_one_out};
	assign {general_out_one_in, indicator_four_in, indicator_three_in, indicator_two_in,
		indicator_one_in} = pin;
	plsc_top #(.SETTLE_CYC(2)) uut (.*);
	plsc_board brd (.strap(strap), .oe(oe), .drv(drv), .pin(pin));
	initial forever #20 mclk = ~mclk;
	task chk(input string nm, input logic [15:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge mclk);
		reg_wr <= 0;
		@(posedge mclk) #1;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] e, input string nm);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge mclk);
		reg_rd <= 0;
		#1 chk(nm, reg_rdata, e);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task await_done;
		for (int i = 0; i < 20 && strap_done !== 1'b1; i++) @(posedge mclk) #1;
		if (strap_done !== 1'b1) begin
			err_count++;
			summarize;
		end
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		chk("pins", {oe, drv}, 16'h0000);
		ext_reset_n <= 1;
		await_done;
		chk("cfg", {strap_mgmt_addr, default_mode, core_regulator_on, auto_crossover_en},
			16'h02B6);
		rd(4'h1, 16'h05B5, "strap");
		strap <= 5'h0A;
		mode_strap <= 3'h2;
		reg_en_strap <= 0;
		rd(4'h1, 16'h05B5, "hold");
		$display("strap test end");
		wr(4'h2, 16'h8001);
		chk("xover", auto_crossover_en, 16'h0001);
		wr(4'h2, 16'h8000);
		chk("xover", auto_crossover_en, 16'h0000);
		wr(4'h2, 16'h0001);
		chk("xover", auto_crossover_en, 16'h0000);
		wr(4'h3, 16'h0001);
		chk("gpo", {general_out_one_out, pin[4]}, 16'h0003);
		rd(4'hF, 16'h0000, "unmapped");
		$display("register test end");
		for (int v = 0; v < 16; v++) begin
			@(posedge mclk);
			{core_speed_fast, core_link_up, core_carrier, core_full_duplex} <= v[3:0];
			repeat (2) @(posedge mclk);
			#1 chk("ind", {drv[3:0], pin[3:0], carrier_sense},
				{v[0], v[1], v[2], v[3], v[0], v[1], v[2], v[3], v[1]});
		end
		rd(4'h0, 16'h000F, "status");
		for (int m = 0; m < 2; m++) begin
			@(posedge mclk);
			rmii_mode <= m[0];
			core_rx_nibble_valid <= 1;
			repeat (2) @(posedge mclk);
			#1 chk("dv", rx_data_valid, !m[0]);
		end
		$display("status test end");
		@(posedge mclk);
		ext_reset_n <= 0;
		auto_crossover_strap <= 1;
		@(posedge mclk);
		ext_reset_n <= 1;
		await_done;
		chk("cfg2", {strap_mgmt_addr, default_mode, core_regulator_on, auto_crossover_en},
			16'h0149);
		$display("reset test end");
		summarize;
	end
endmodule
